// ---- dcc_regs.vh ----
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// Register indexes; the byte address on the bus is four times the index
`define DCC_IDX_CONFIG 10'h330
`define DCC_IDX_EXTEND 10'h331
`define DCC_IDX_STATUS 10'h33f

`define DCC_CONFIG_RESET 8'h00
`define DCC_EXTEND_RESET 4'h0

// Fields of channel1_downconv_config
`define DCC_GAIN_BIT 6
`define DCC_IFMODE_HI 5
`define DCC_IFMODE_LO 4
`define DCC_C2R_BIT 3
`define DCC_PRIDEC_HI 2
`define DCC_PRIDEC_LO 0

// Field of channel1_decim_extension; bits [3:0] read as zero
`define DCC_SECDEC_HI 7
`define DCC_SECDEC_LO 4

// Fields of the status register
`define DCC_STAT_FACTOR_HI 5
`define DCC_STAT_FACTOR_LO 0
`define DCC_STAT_BADCODE_BIT 6
`define DCC_STAT_NOHALF_BIT 7

// IF mode codes
`define DCC_IF_VARIABLE 2'h0
`define DCC_IF_ZERO 2'h1
`define DCC_IF_FS 2'h2
`define DCC_IF_TEST 2'h3

// Primary decimation codes
`define DCC_PRI_HB12 3'h0
`define DCC_PRI_HB123 3'h1
`define DCC_PRI_HB1234 3'h2
`define DCC_PRI_HB1 3'h3
`define DCC_PRI_HB1_TB2 3'h4
`define DCC_PRI_HB12_TB2 3'h5
`define DCC_PRI_HB123_TB2 3'h6
`define DCC_PRI_EXT 3'h7

// Secondary decimation codes
`define DCC_SEC_TB2_HB1234 4'h0
`define DCC_SEC_FB_HB1 4'h2
`define DCC_SEC_FB_HB12 4'h3
`define DCC_SEC_FB_HB123 4'h4
`define DCC_SEC_TB1 4'h7
`define DCC_SEC_TB1_FB 4'h8
`define DCC_SEC_TB1_FB_HB2 4'h9

// Stage enable mask bits, also the chain position of each stage
`define DCC_M_TB1 7'h01
`define DCC_M_FB 7'h02
`define DCC_M_HB1 7'h04
`define DCC_M_HB2 7'h08
`define DCC_M_HB3 7'h10
`define DCC_M_HB4 7'h20
`define DCC_M_TB2 7'h40
`define DCC_STAGES 7

`define DCC_SAMPLE_W 16

`endif

// ---- dcc_decim_stage.v ----
`timescale 1ns/10ps
`include "dcc_regs.vh"

// One decimation stage: keeps one sample of every FACTOR when switched on,
// otherwise passes every sample through with one cycle of latency.
// Filtering taps are not modelled here; only the rate change is.
module dcc_decim_stage #(
  parameter FACTOR = 2
) (
  input wire clock,
  input wire rst,
  input wire stageOn,
  input wire inValid,
  input wire [`DCC_SAMPLE_W-1:0] inI,
  input wire [`DCC_SAMPLE_W-1:0] inQ,
  output reg outValid,
  output reg [`DCC_SAMPLE_W-1:0] outI,
  output reg [`DCC_SAMPLE_W-1:0] outQ
);
  localparam integer LAST_I = FACTOR - 1;
  localparam [2:0] LAST = LAST_I[2:0];

  reg [2:0] phase;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 3'h0;
      outValid <= 1'b0;
      outI <= 16'h0000;
      outQ <= 16'h0000;
    end else begin
      outValid <= 1'b0;
      if (!stageOn) begin
        // Restart the phase so a newly enabled stage starts cleanly
        phase <= 3'h0;
      end
      if (inValid) begin
        if (!stageOn || phase == 3'h0) begin
          outValid <= 1'b1;
          outI <= inI;
          outQ <= inQ;
        end
        if (stageOn) begin
          phase <= (phase == LAST) ? 3'h0 : phase + 3'h1;
        end
      end
    end
  end
endmodule

// ---- dcc_channel_config.v ----
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dcc_regs.vh"

module dcc_channel_config (
  input wire clock,
  input wire rst,
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire inValid,
  input wire [`DCC_SAMPLE_W-1:0] inI,
  input wire [`DCC_SAMPLE_W-1:0] inQ,
  output reg outValid,
  output reg outQValid,
  output reg [`DCC_SAMPLE_W-1:0] outI,
  output reg [`DCC_SAMPLE_W-1:0] outQ,
  output reg ncoBypass,
  output reg testModeActive
);
  localparam W = `DCC_SAMPLE_W;

  reg [7:0] configReg;
  reg [3:0] secDecim;
  reg [`DCC_STAGES-1:0] stageMask;
  // Status shows the factor actually applied, after real-mode halving
  reg [5:0] effFactor;
  reg badCode;
  reg noHalf;
  reg [W-1:0] ramp;
  reg realPhase;

  reg [`DCC_STAGES-1:0] next_stageMask;
  reg [5:0] next_factor;
  reg next_halvable;
  reg next_badCode;
  reg [7:0] regValue;
  reg [W-1:0] sampleI;
  reg [W-1:0] sampleQ;

  wire request;
  wire [9:0] regIndex;
  wire aligned;
  wire gainOn;
  wire realOn;
  wire [1:0] ifMode;
  wire [2:0] priDecim;
  wire [W-1:0] stageInI;
  wire [W-1:0] stageInQ;
  // Samples between stages: slot 0 is the chain input, then one slot per stage output
  wire [`DCC_STAGES:0] chainValid;
  wire [(`DCC_STAGES+1)*W-1:0] chainI;
  wire [(`DCC_STAGES+1)*W-1:0] chainQ;
  wire [W-1:0] chainOutI;

  assign request = read | write;
  assign regIndex = address[11:2];
  assign aligned = (address[1:0] == 2'h0);
  assign gainOn = configReg[`DCC_GAIN_BIT];
  assign realOn = configReg[`DCC_C2R_BIT];
  assign ifMode = configReg[`DCC_IFMODE_HI:`DCC_IFMODE_LO];
  assign priDecim = configReg[`DCC_PRIDEC_HI:`DCC_PRIDEC_LO];

  // Doubling with saturation so a full-scale sample does not wrap
  function [W-1:0] doubleSat;
    input [W-1:0] x;
    begin
      if (x[W-1] != x[W-2]) begin
        doubleSat = x[W-1] ? 16'h8000 : 16'h7fff;
      end else begin
        doubleSat = {x[W-2:0], 1'b0};
      end
    end
  endfunction

  // Negation clipped at the most negative code, which has no positive twin
  function [W-1:0] negSat;
    input [W-1:0] x;
    begin
      if (x == 16'h8000) begin
        negSat = 16'h7fff;
      end else begin
        negSat = ~x + 16'h0001;
      end
    end
  endfunction

  // Filter chain decode. Factor is the complex-output decimation; real
  // output drops the first half-band where the chain allows it.
  always @* begin
    next_stageMask = 7'h00;
    next_factor = 6'h01;
    next_halvable = 1'b1;
    next_badCode = 1'b0;
    case (priDecim)
      `DCC_PRI_HB12: begin
        next_stageMask = `DCC_M_HB1 | `DCC_M_HB2;
        next_factor = 6'd4;
      end
      `DCC_PRI_HB123: begin
        next_stageMask = `DCC_M_HB1 | `DCC_M_HB2 | `DCC_M_HB3;
        next_factor = 6'd8;
      end
      `DCC_PRI_HB1234: begin
        next_stageMask = `DCC_M_HB1 | `DCC_M_HB2 | `DCC_M_HB3 | `DCC_M_HB4;
        next_factor = 6'd16;
      end
      `DCC_PRI_HB1: begin
        next_stageMask = `DCC_M_HB1;
        next_factor = 6'd2;
      end
      `DCC_PRI_HB1_TB2: begin
        next_stageMask = `DCC_M_HB1 | `DCC_M_TB2;
        next_factor = 6'd6;
      end
      `DCC_PRI_HB12_TB2: begin
        next_stageMask = `DCC_M_HB1 | `DCC_M_HB2 | `DCC_M_TB2;
        next_factor = 6'd12;
      end
      `DCC_PRI_HB123_TB2: begin
        next_stageMask = `DCC_M_HB1 | `DCC_M_HB2 | `DCC_M_HB3 | `DCC_M_TB2;
        next_factor = 6'd24;
      end
      `DCC_PRI_EXT: begin
        // Secondary field is looked at only on this code
        case (secDecim)
          `DCC_SEC_TB2_HB1234: begin
            next_stageMask = `DCC_M_TB2 | `DCC_M_HB4 | `DCC_M_HB3 | `DCC_M_HB2
              | `DCC_M_HB1;
            next_factor = 6'd48;
          end
          `DCC_SEC_FB_HB1: begin
            next_stageMask = `DCC_M_FB | `DCC_M_HB1;
            next_factor = 6'd10;
          end
          `DCC_SEC_FB_HB12: begin
            next_stageMask = `DCC_M_FB | `DCC_M_HB2 | `DCC_M_HB1;
            next_factor = 6'd20;
          end
          `DCC_SEC_FB_HB123: begin
            next_stageMask = `DCC_M_FB | `DCC_M_HB3 | `DCC_M_HB2 | `DCC_M_HB1;
            next_factor = 6'd40;
          end
          `DCC_SEC_TB1: begin
            next_stageMask = `DCC_M_TB1;
            next_factor = 6'd3;
            next_halvable = 1'b0;
          end
          `DCC_SEC_TB1_FB: begin
            next_stageMask = `DCC_M_TB1 | `DCC_M_FB;
            next_factor = 6'd15;
            next_halvable = 1'b0;
          end
          `DCC_SEC_TB1_FB_HB2: begin
            next_stageMask = `DCC_M_TB1 | `DCC_M_FB | `DCC_M_HB2;
            next_factor = 6'd30;
            next_halvable = 1'b0;
          end
          default: begin
            // Unlisted code: all stages bypassed and the status flags it
            next_stageMask = 7'h00;
            next_factor = 6'h01;
            next_halvable = 1'b0;
            next_badCode = 1'b1;
          end
        endcase
      end
      default: begin
        // Unreachable: every primary code is listed above
        next_stageMask = 7'h00;
        next_factor = 6'h01;
      end
    endcase
  end

  // Decoded chain is registered; a change takes effect one cycle after the write
  // Registering the decode keeps the long case off the stage enable path
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stageMask <= 7'h00;
      effFactor <= 6'h01;
      badCode <= 1'b0;
      noHalf <= 1'b0;
    end else begin
      badCode <= next_badCode;
      noHalf <= realOn & ~next_halvable & ~next_badCode;
      if (realOn && next_halvable) begin
        // Real output halves the rate by dropping the first half-band
        stageMask <= next_stageMask & ~`DCC_M_HB1;
        effFactor <= {1'b0, next_factor[5:1]};
      end else begin
        stageMask <= next_stageMask;
        effFactor <= next_factor;
      end
    end
  end

  // Register read mux
  // Unaligned or unmapped reads return zero rather than aliasing a register
  always @* begin
    regValue = 8'h00;
    if (aligned) begin
      case (regIndex)
        `DCC_IDX_CONFIG: regValue = configReg;
        `DCC_IDX_EXTEND: regValue = {secDecim, 4'h0};
        `DCC_IDX_STATUS: regValue = {noHalf, badCode, effFactor};
        default: regValue = 8'h00;
      endcase
    end
  end

  // Avalon slave: waitrequest drops for one cycle, one edge after the request
  // A registered answer costs one cycle per access but never glitches
  // Writes land on the edge at which the master sees waitrequest low
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      configReg <= `DCC_CONFIG_RESET;
      secDecim <= `DCC_EXTEND_RESET;
    end else begin
      waitrequest <= 1'b1;
      if (request && waitrequest) begin
        waitrequest <= 1'b0;
        readdata <= read ? {24'h000000, regValue} : 32'h00000000;
      end
      if (write && !waitrequest && aligned && byteenable[0]) begin
        if (regIndex == `DCC_IDX_CONFIG) begin
          configReg <= writedata[7:0];
        end
        if (regIndex == `DCC_IDX_EXTEND) begin
          secDecim <= writedata[`DCC_SECDEC_HI:`DCC_SECDEC_LO];
        end
      end
    end
  end

  // Test mode replaces the converter samples with a ramp
  // The ramp steps only on input strobes, so it follows the sample rate
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ramp <= 16'h0000;
      ncoBypass <= 1'b0;
      testModeActive <= 1'b0;
    end else begin
      if (inValid) begin
        ramp <= ramp + 16'h0001;
      end
      // Mixing at 0 Hz or at the sample rate leaves the samples unrotated
      ncoBypass <= (ifMode == `DCC_IF_ZERO) || (ifMode == `DCC_IF_FS);
      testModeActive <= (ifMode == `DCC_IF_TEST);
    end
  end

  // Test samples enter ahead of the chain so they see the same decimation
  always @* begin
    sampleI = inI;
    sampleQ = inQ;
    if (ifMode == `DCC_IF_TEST) begin
      sampleI = ramp;
      sampleQ = ~ramp;
    end
  end

  assign stageInI = sampleI;
  assign stageInQ = sampleQ;
  assign chainValid[0] = inValid;
  assign chainI[W-1:0] = stageInI;
  assign chainQ[W-1:0] = stageInQ;

  // Chain order TB1, FB, HB1 to HB4, TB2; position g matches the mask bit
  // A stage that is off still costs one cycle, so latency never depends on mode
  genvar g;
  generate
    for (g = 0; g < `DCC_STAGES; g = g + 1) begin : stage
      dcc_decim_stage #(
        .FACTOR((g == 0 || g == 6) ? 3 : (g == 1) ? 5 : 2)
      ) u_stage (
        .clock(clock),
        .rst(rst),
        .stageOn(stageMask[g]),
        .inValid(chainValid[g]),
        .inI(chainI[g*W +: W]),
        .inQ(chainQ[g*W +: W]),
        .outValid(chainValid[g+1]),
        .outI(chainI[(g+1)*W +: W]),
        .outQ(chainQ[(g+1)*W +: W])
      );
    end
  endgenerate

  // Gain sits after decimation, where the word rate is lowest
  assign chainOutI = gainOn ? doubleSat(chainI[`DCC_STAGES*W +: W]) :
    chainI[`DCC_STAGES*W +: W];

  // Output stage: gain, then complex or real delivery
  // realPhase restarts whenever real mode is left, so the first real sample keeps its sign
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outQValid <= 1'b0;
      outI <= 16'h0000;
      outQ <= 16'h0000;
      realPhase <= 1'b0;
    end else begin
      outValid <= chainValid[`DCC_STAGES];
      outQValid <= chainValid[`DCC_STAGES] & ~realOn;
      if (!realOn) begin
        realPhase <= 1'b0;
      end
      if (chainValid[`DCC_STAGES]) begin
        if (realOn) begin
          // Alternate sign gives the extra sample-rate mix
          outI <= realPhase ? negSat(chainOutI) : chainOutI;
          outQ <= 16'h0000;
          realPhase <= ~realPhase;
        end else begin
          outI <= chainOutI;
          outQ <= gainOn ? doubleSat(chainQ[`DCC_STAGES*W +: W]) :
            chainQ[`DCC_STAGES*W +: W];
        end
      end
    end
  end
endmodule

// ---- dcc_chk_properties.sv ----
`timescale 1ns/10ps
module dcc_chk (
  input wire clock,
  input wire rst,
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire inValid,
  input wire outValid,
  input wire outQValid,
  input wire [15:0] outQ,
  input wire ncoBypass,
  input wire testModeActive
);
  reg [1:0] lastMode;
  wire cfgWr = write && !waitrequest && byteenable[0] && address == 12'hcc0;
  always @(posedge clock or posedge rst) begin
    if (rst)
      lastMode <= 2'h0;
    else if (cfgWr)
      lastMode <= writedata[5:4];
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  AST_ONE_LOW: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_IDLE: assert property (!read && !write && waitrequest |=> waitrequest)
    else $error("answer without request");
  AST_EXT_RSVD: assert property (read && !waitrequest && address == 12'hcc4 |->
    readdata[3:0] == 4'h0 && readdata[31:8] == 24'h0) else $error("reserved bits not zero");
  AST_IFMODE: assert property (cfgWr |-> ##[1:3] testModeActive == (lastMode == 2'h3) &&
    ncoBypass == (lastMode[1] ^ lastMode[0])) else $error("IF mode outputs wrong");
  AST_MODE_EXCL: assert property (!(ncoBypass && testModeActive))
    else $error("two IF modes at once");
  AST_Q_WITH_I: assert property (outQValid |-> outValid)
    else $error("quadrature without in-phase");
  AST_REAL_Q: assert property (outValid && !outQValid |-> outQ == 16'h0)
    else $error("quadrature data in real mode");
  AST_LATENCY: assert property (outValid |-> $past(inValid, 8))
    else $error("output without input eight cycles before");
endmodule

// ---- dcc_stream_src.sv ----
`timescale 1ns/10ps
module dcc_stream_src (
  input wire clock,
  input wire rst,
  input wire slow,
  input wire [15:0] level,
  input wire [31:0] quota,
  output reg inValid,
  output reg [15:0] inI,
  output reg [15:0] inQ,
  output reg [31:0] sent
);
  reg [1:0] phase;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      inValid <= 1'b0;
      inI <= 16'h0;
      inQ <= 16'h0;
      sent <= 32'h0;
      phase <= 2'h0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      if (sent != quota && (!slow || phase == 2'h0)) begin
        inValid <= 1'b1;
        inI <= level;
        inQ <= -level;
        sent <= sent + 32'h1;
      end else begin
        // Idle lines keep toggling so a stale sample is never read as fresh
        inValid <= 1'b0;
        inI <= ~inI;
        inQ <= ~inQ;
      end
    end
  end
endmodule

// ---- downconverter_ch1_decim_config_tb.sv ----
`timescale 1ns/10ps
module downconverter_ch1_decim_config_tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [11:0] address = 12'h0;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] byteenable = 4'h1;
  reg slow = 1'b0;
  reg [15:0] level = 16'h0100;
  reg [31:0] quota = 32'h0;
  wire [31:0] sent;
  wire [31:0] readdata;
  wire waitrequest, inValid, outValid, outQValid, ncoBypass, testModeActive;
  wire [15:0] inI, inQ, outI, outQ;
  integer errCount = 0;
  integer compares = 0;
  integer outCnt = 0;
  integer qCnt = 0;
  integer c0, q0, i, r;
  reg [15:0] lastI, prevI, lastQ;
  reg [31:0] q;
  reg [7:0] f;
  reg [7:0] fc [0:13] = '{8'h04, 8'h08, 8'h10, 8'h02, 8'h06, 8'h0c, 8'h18,
    8'h30, 8'h0a, 8'h14, 8'h28, 8'h03, 8'h0f, 8'h1e};
  reg [7:0] fr [0:13] = '{8'h02, 8'h04, 8'h08, 8'h01, 8'h03, 8'h06, 8'h0c,
    8'h18, 8'h05, 8'h0a, 8'h14, 8'h03, 8'h0f, 8'h1e};
  reg [3:0] sc [0:6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};

  always #20 clock = ~clock;

  dcc_channel_config u_dut (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .inValid(inValid), .inI(inI), .inQ(inQ),
    .outValid(outValid), .outQValid(outQValid), .outI(outI), .outQ(outQ),
    .ncoBypass(ncoBypass), .testModeActive(testModeActive));

  dcc_stream_src u_src (.clock(clock), .rst(rst), .slow(slow), .level(level),
    .quota(quota), .inValid(inValid), .inI(inI), .inQ(inQ), .sent(sent));

  always @(posedge clock) begin
    if (outValid === 1'b1) begin
      outCnt <= outCnt + 1;
      qCnt <= qCnt + outQValid;
      prevI <= lastI;
      lastI <= outI;
      lastQ <= outQ;
    end
  end

  task summarize;
    begin
      $display("mismatches %0d of %0d compares", errCount, compares);
      if (errCount == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errCount = errCount + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task bus(input w, input [11:0] a, input [7:0] d);
    integer k;
    begin
      @(posedge clock);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h0, d};
      k = 0;
      do begin
        @(posedge clock);
        k = k + 1;
      end while (waitrequest !== 1'b0 && k < 50);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (k >= 50) begin
        errCount = errCount + 1;
        summarize;
      end
    end
  endtask

  // Fixed 240 samples: every factor divides it, so stage phase cannot skew counts
  task mode(input [7:0] c, input [7:0] e, input [7:0] st);
    integer k;
    begin
      bus(1'b1, 12'hcc4, e);
      bus(1'b1, 12'hcc0, c);
      bus(1'b0, 12'hcfc, 8'h0);
      chk(q, st);
      c0 = outCnt;
      q0 = qCnt;
      @(posedge clock);
      quota <= quota + 240;
      k = 0;
      do begin
        @(posedge clock);
        k = k + 1;
      end while (sent !== quota && k < 2000);
      repeat (20) @(posedge clock);
      if (k >= 2000) begin
        errCount = errCount + 1;
        summarize;
      end
      chk(outCnt - c0, 240 / st[5:0]);
      chk(qCnt - q0, c[3] ? 0 : 240 / st[5:0]);
    end
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 12'hcc0, 8'h0);
    chk(q, 32'h0);
    bus(1'b0, 12'hcc4, 8'h0);
    chk(q, 32'h0);
    bus(1'b0, 12'hcfc, 8'h0);
    chk(q, 32'h04);
    bus(1'b1, 12'h100, 8'hff);
    bus(1'b0, 12'h100, 8'h0);
    chk(q, 32'h0);
    byteenable <= 4'h0;
    bus(1'b1, 12'hcc0, 8'h55);
    byteenable <= 4'h1;
    bus(1'b0, 12'hcc0, 8'h0);
    chk(q, 32'h0);
    bus(1'b1, 12'hcc1, 8'h55);
    bus(1'b0, 12'hcc0, 8'h0);
    chk(q, 32'h0);
    bus(1'b0, 12'hcc1, 8'h0);
    chk(q, 32'h0);
    bus(1'b1, 12'hcc4, 8'hff);
    bus(1'b0, 12'hcc4, 8'h0);
    chk(q, 32'hf0);
    for (i = 0; i < 7; i = i + 1) begin
      for (r = 0; r < 2; r = r + 1) begin
        slow <= r[0];
        f = r[0] ? fr[i] : fc[i];
        mode({4'h0, r[0], i[2:0]}, 8'h90, f);
        f = r[0] ? fr[i + 7] : fc[i + 7];
        mode({4'h0, r[0], 3'h7}, {sc[i], 4'h0}, {r[0] && i > 3, 1'b0, f[5:0]});
      end
    end
    slow <= 1'b0;
    mode(8'h07, 8'h10, 8'h41);
    mode(8'h0f, 8'h10, 8'h41);
    level <= 16'h1234;
    mode(8'h43, 8'h0, 8'h02);
    chk(lastI, 16'h2468);
    chk(lastQ, 16'hdb98);
    level <= 16'h5000;
    mode(8'h43, 8'h0, 8'h02);
    chk(lastI, 16'h7fff);
    chk(lastQ, 16'h8000);
    level <= 16'h0100;
    mode(8'h03, 8'h0, 8'h02);
    chk(lastI, 16'h0100);
    mode(8'h0b, 8'h0, 8'h01);
    chk(prevI, 16'h0100);
    chk(lastI, 16'hff00);
    chk(lastQ, 16'h0);
    bus(1'b1, 12'hcc0, 8'h8b);
    bus(1'b0, 12'hcc0, 8'h0);
    chk(q, 32'h8b);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b1, 12'hcc0, {2'h0, i[1:0], 4'h0});
      repeat (4) @(posedge clock);
      chk({ncoBypass, testModeActive}, i == 3 ? 1 : ((i == 1 || i == 2) ? 2 : 0));
    end
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 12'hcc0, 8'h0);
    chk(q, 32'h0);
    bus(1'b0, 12'hcfc, 8'h0);
    chk(q, 32'h04);
    summarize;
  end
endmodule

bind dcc_channel_config dcc_chk u_chk (.clock(clock), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .inValid(inValid), .outValid(outValid),
  .outQValid(outQValid), .outQ(outQ), .ncoBypass(ncoBypass),
  .testModeActive(testModeActive));
